// ===== include/csi_pkg.sv
// Package of register offsets, field positions, reset value and frame length for the serial port.
package csi_pkg;
  // Register byte addresses (low 16 bits of paddr).
  localparam logic [15:0] OFF_CH0_MODE = 16'hff80;
  localparam logic [15:0] OFF_CH0_CLK  = 16'hff81;
  localparam logic [15:0] OFF_CH0_TXB  = 16'hff84;
  localparam logic [15:0] OFF_CH0_SHR  = 16'hff8c;
  localparam logic [15:0] OFF_CH1_MODE = 16'hff88;
  localparam logic [15:0] OFF_CH1_CLK  = 16'hff89;
  localparam logic [15:0] OFF_CH1_TXB  = 16'hff90;
  localparam logic [15:0] OFF_CH1_SHR  = 16'hff94;
  // Mode register fields.
  localparam int MODE_EN_BIT   = 7;
  localparam int MODE_TXRX_BIT = 6;
  localparam int MODE_SSE_BIT  = 5;
  localparam int MODE_DIR_BIT  = 4;
  localparam int MODE_BUSY_BIT = 0;
  localparam logic [7:0] MODE_WMASK_CH0 = 8'hd0;
  localparam logic [7:0] MODE_WMASK_CH1 = 8'hf0;
  // Clock select register fields.
  localparam int CLK_POL_BIT   = 4;
  localparam int CLK_PHA_BIT   = 3;
  localparam logic [7:0] CLK_WMASK = 8'h1f;
  localparam logic [2:0] CLK_SRC_SLAVE = 3'b111;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int FRAME_BITS = 8;
endpackage

// ===== src/csi_port.sv
// Two-channel three-wire clocked serial port with an APB register slave.
//
// Our own choice: the APB register port.
module csi_port #(
  parameter int NUM_CH = 2
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [NUM_CH-1:0] serial_clock_line_in,
  output logic      [NUM_CH-1:0] serial_clock_line_out,
  output logic      [NUM_CH-1:0] serial_clock_line_oe,
  input  wire logic [NUM_CH-1:0] serial_in_line,
  output logic      [NUM_CH-1:0] serial_out_line,
  input  wire logic              slave_select_in_n,
  output logic      [NUM_CH-1:0] transfer_done_irq
);
  initial begin
    if (NUM_CH < 1 || NUM_CH > 2) begin
      $error("csi_port supports one or two channels only");
    end
  end

  // APB access strobes; the slave answers with no wait states.
  wire apb_wr = psel && penable && pwrite;
  wire apb_rd = psel && penable && !pwrite;
  assign pready = 1'b1;

  // Slave select shared by channel one, synchronised since it is a pin.
  logic ss_meta_q;
  logic ss_sync_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ss_meta_q <= 1'b1;
      ss_sync_q <= 1'b1;
    end else if (clk_en) begin
      ss_meta_q <= slave_select_in_n;
      ss_sync_q <= ss_meta_q;
    end
  end

  logic [7:0]  ch_rdata [NUM_CH];
  logic [NUM_CH-1:0] ch_hit;
  logic [NUM_CH-1:0] ch_busy;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      localparam logic [15:0] A_MODE = (g == 0) ? csi_pkg::OFF_CH0_MODE : csi_pkg::OFF_CH1_MODE;
      localparam logic [15:0] A_CLK  = (g == 0) ? csi_pkg::OFF_CH0_CLK  : csi_pkg::OFF_CH1_CLK;
      localparam logic [15:0] A_TXB  = (g == 0) ? csi_pkg::OFF_CH0_TXB  : csi_pkg::OFF_CH1_TXB;
      localparam logic [15:0] A_SHR  = (g == 0) ? csi_pkg::OFF_CH0_SHR  : csi_pkg::OFF_CH1_SHR;
      localparam logic [7:0]  WMASK  = (g == 0) ? csi_pkg::MODE_WMASK_CH0
                                                : csi_pkg::MODE_WMASK_CH1;

      // Address decode for this channel.
      wire sel_mode = (paddr[15:0] == A_MODE);
      wire sel_clk  = (paddr[15:0] == A_CLK);
      wire sel_txb  = (paddr[15:0] == A_TXB);
      wire sel_shr  = (paddr[15:0] == A_SHR);
      assign ch_hit[g] = sel_mode || sel_clk || sel_txb || sel_shr;

      logic [7:0] mode_q;
      logic [7:0] clk_q;
      logic [7:0] txb_q;
      logic [7:0] shr_q;
      logic       busy_q;
      logic [3:0] bitcnt_q;
      logic [7:0] div_q;
      logic       sck_q;
      logic       so_q;
      logic       done_q;
      logic       sck_meta_q, sck_sync_q, sck_prev_q;
      logic       si_meta_q, si_sync_q;

      wire enable    = mode_q[csi_pkg::MODE_EN_BIT];
      wire txrx      = mode_q[csi_pkg::MODE_TXRX_BIT];
      wire lsb_first = mode_q[csi_pkg::MODE_DIR_BIT];
      wire sse       = (g == 1) && mode_q[csi_pkg::MODE_SSE_BIT];
      wire pol       = clk_q[csi_pkg::CLK_POL_BIT];
      wire pha       = clk_q[csi_pkg::CLK_PHA_BIT];
      wire [2:0] src = clk_q[2:0];
      wire slave     = (src == csi_pkg::CLK_SRC_SLAVE);
      // Inactive select gates off the slave's clock edges and serial output; software can still start it.
      wire ss_block  = slave && sse && ss_sync_q;

      // Start conditions from software accesses.
      wire wr_txb    = apb_wr && sel_txb;
      wire start_tx  = wr_txb && enable && txrx && !busy_q;
      wire start_rx  = apb_rd && sel_shr && enable && !txrx && !busy_q;

      // Master divider: code k divides by 2^(k+1), giving half period 2^k.
      wire [7:0] half_lim = 8'(8'h01 << src) - 8'h01;
      wire m_tick = !slave && busy_q && (div_q == half_lim);
      // Slave edges come from the synchronised external clock.
      wire s_rise = slave && sck_sync_q && !sck_prev_q;
      wire s_fall = slave && !sck_sync_q && sck_prev_q;
      // Line level relative to idle: leading edge leaves idle level.
      wire m_lead  = m_tick && !sck_q;
      wire m_trail = m_tick && sck_q;
      wire s_lead  = pol ? s_fall : s_rise;
      wire s_trail = pol ? s_rise : s_fall;
      wire lead    = (m_lead || s_lead) && busy_q && !ss_block;
      wire trail   = (m_trail || s_trail) && busy_q && !ss_block;
      // Type 1 and 3 sample on the trailing edge, 2 and 4 on the leading one.
      wire sample_ev = pha ? lead : trail;
      // The next bit moves out only on the trailing edge, after the sample, so the
      // first bit set up at start is held through the first leading edge.
      wire shift_ev  = trail;
      wire last_bit  = (bitcnt_q == 4'(csi_pkg::FRAME_BITS - 1));
      wire [7:0] shr_in = lsb_first ? {si_sync_q, shr_q[7:1]}
                                    : {shr_q[6:0], si_sync_q};
      wire next_out = lsb_first ? shr_q[1] : shr_q[6];
      wire first_out = lsb_first ? pwdata[0] : pwdata[7];

      // Serial pin synchronisers, both pins come from outside.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sck_meta_q <= 1'b0;
          sck_sync_q <= 1'b0;
          sck_prev_q <= 1'b0;
          si_meta_q  <= 1'b0;
          si_sync_q  <= 1'b0;
        end else if (clk_en) begin
          sck_meta_q <= serial_clock_line_in[g];
          sck_sync_q <= sck_meta_q;
          sck_prev_q <= sck_sync_q;
          si_meta_q  <= serial_in_line[g];
          si_sync_q  <= si_meta_q;
        end
      end

      // Software-written control registers; busy bit is never stored.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mode_q <= csi_pkg::RESET_BYTE;
          clk_q  <= csi_pkg::RESET_BYTE;
          txb_q  <= csi_pkg::RESET_BYTE;
        end else if (clk_en) begin
          if (apb_wr && sel_mode) mode_q <= pwdata[7:0] & WMASK;
          if (apb_wr && sel_clk)  clk_q  <= pwdata[7:0] & csi_pkg::CLK_WMASK;
          if (wr_txb)             txb_q  <= pwdata[7:0];
        end
      end

      // Transfer engine; a cleared enable holds it in reset.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          shr_q    <= csi_pkg::RESET_BYTE;
          busy_q   <= 1'b0;
          bitcnt_q <= 4'h0;
          div_q    <= 8'h00;
          sck_q    <= 1'b0;
          so_q     <= 1'b0;
          done_q   <= 1'b0;
        end else if (clk_en) begin
          done_q <= 1'b0;
          if (!enable) begin
            shr_q    <= csi_pkg::RESET_BYTE;
            busy_q   <= 1'b0;
            bitcnt_q <= 4'h0;
            div_q    <= 8'h00;
            sck_q    <= 1'b0;
            so_q     <= 1'b0;
          end else if (start_tx || start_rx) begin
            busy_q   <= 1'b1;
            bitcnt_q <= 4'h0;
            div_q    <= 8'h00;
            sck_q    <= 1'b0;
            shr_q    <= start_tx ? pwdata[7:0] : shr_q;
            so_q     <= start_tx && first_out;
          end else if (busy_q) begin
            div_q <= m_tick ? 8'h00 : 8'(div_q + 8'h01);
            if (m_tick) sck_q <= !sck_q;
            if (sample_ev) begin
              shr_q <= shr_in;
              if (last_bit && pha) begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
              end
            end
            if (shift_ev) begin
              if (txrx) so_q <= next_out;
              if (!pha) begin
                bitcnt_q <= 4'(bitcnt_q + 4'h1);
                if (last_bit) begin
                  busy_q <= 1'b0;
                  done_q <= 1'b1;
                end
              end
            end
            if (sample_ev && pha) bitcnt_q <= 4'(bitcnt_q + 4'h1);
          end
        end
      end

      // Pins: master drives the clock at polarity; the output follows txrx.
      assign serial_clock_line_out[g] = sck_q ^ pol;
      assign serial_clock_line_oe[g]  = enable && !slave;
      assign serial_out_line[g]       = txrx && !ss_block && so_q;
      assign transfer_done_irq[g]     = done_q;
      assign ch_busy[g]               = busy_q;
      assign ch_rdata[g] = sel_mode ? {mode_q[7:1], busy_q} :
                           sel_clk  ? clk_q :
                           sel_txb  ? txb_q :
                           sel_shr  ? shr_q : 8'h00;
    end
  endgenerate

  // Read data and error answer; unmapped addresses answer with pslverr.
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    for (int i = 0; i < NUM_CH; i++) begin
      if (ch_hit[i]) rd_mux = ch_rdata[i];
    end
  end
  assign prdata  = {24'h00_0000, rd_mux};
  assign pslverr = psel && penable && (ch_hit == '0);

  // Busy flag drops in the same cycle that the done pulse is seen.
  for (g = 0; g < NUM_CH; g++) begin : g_chk
    property p_done_clears_busy;
      @(posedge pclk) disable iff (!presetn)
        transfer_done_irq[g] |-> !ch_busy[g];
    endproperty
    a_done_clears_busy: assert property (p_done_clears_busy)
      else $error("done pulse while still busy");
    property p_done_one_cycle;
      @(posedge pclk) disable iff (!presetn)
        (clk_en && transfer_done_irq[g]) |=> !transfer_done_irq[g];
    endproperty
    a_done_one_cycle: assert property (p_done_one_cycle)
      else $error("done pulse longer than one clock");
    property p_busy_fall_done;
      @(posedge pclk) disable iff (!presetn)
        $fell(ch_busy[g]) && g_ch[g].enable |-> transfer_done_irq[g];
    endproperty
    a_busy_fall_done: assert property (p_busy_fall_done)
      else $error("busy fell without done pulse");
    property p_disable_reset;
      @(posedge pclk) disable iff (!presetn)
        (clk_en && !g_ch[g].enable) |=> (!ch_busy[g] && g_ch[g].shr_q == 8'h00);
    endproperty
    a_disable_reset: assert property (p_disable_reset)
      else $error("disabled channel not cleared");
    property p_rx_out_low;
      @(posedge pclk) disable iff (!presetn)
        !g_ch[g].txrx |-> !serial_out_line[g];
    endproperty
    a_rx_out_low: assert property (p_rx_out_low)
      else $error("output driven in receive mode");
    property p_tx_start;
      @(posedge pclk) disable iff (!presetn)
        (clk_en && g_ch[g].start_tx) |=> (ch_busy[g] && g_ch[g].shr_q == $past(pwdata[7:0]));
    endproperty
    a_tx_start: assert property (p_tx_start)
      else $error("transmit write did not start transfer");
    property p_rx_start;
      @(posedge pclk) disable iff (!presetn)
        (clk_en && g_ch[g].start_rx) |=> ch_busy[g];
    endproperty
    a_rx_start: assert property (p_rx_start)
      else $error("shift register read did not start receive");
    property p_ss_block;
      @(posedge pclk) disable iff (!presetn)
        g_ch[g].ss_block |-> !serial_out_line[g];
    endproperty
    a_ss_block: assert property (p_ss_block)
      else $error("output driven while deselected");
  end
endmodule

// ===== bench/csi_peer.sv
// Far-side peripheral model: sends a reply byte and captures what the port shifts out.
module csi_peer (
  input  wire logic       sck,
  input  wire logic       so,
  input  wire logic       clr,
  input  wire logic [7:0] reply,
  output logic            si,
  output logic      [7:0] got
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_q;

  // The port's output is captured on the leading edge, where it is steady.
  always @(posedge sck) begin
    got <= {got[6:0], so};
  end

  // The reply advances after the trailing edge, where the port has taken its bit.
  always @(negedge sck or posedge clr) begin
    if (clr) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  // The reply always goes MSB first, so the bench reverses its view in LSB mode.
  assign si = reply[3'h7 - cnt_q];
endmodule

// ===== bench/three_wire_clocked_serial_port_tb.sv
// Self-checking bench for the two-channel three-wire serial port.
module three_wire_clocked_serial_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        clr = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rnd = 32'h66e1_4484;
  logic        pready;
  logic        pslverr;
  logic [1:0]  sck_o;
  logic [1:0]  si;
  logic [1:0]  so;
  logic [1:0]  irq;
  logic [7:0]  reply[2];
  logic [7:0]  got[2];
  logic [15:0] a_mode[2] = '{csi_pkg::OFF_CH0_MODE, csi_pkg::OFF_CH1_MODE};
  logic [15:0] a_clk[2] = '{csi_pkg::OFF_CH0_CLK, csi_pkg::OFF_CH1_CLK};
  logic [15:0] a_txb[2] = '{csi_pkg::OFF_CH0_TXB, csi_pkg::OFF_CH1_TXB};
  logic [15:0] a_shr[2] = '{csi_pkg::OFF_CH0_SHR, csi_pkg::OFF_CH1_SHR};
  int          err_total = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          irqs[2] = '{0, 0};

  // Slave clock and slave select stay idle: this bench exercises master mode only.
  // Channel zero mode writes always keep bit five clear.
  csi_port #(.NUM_CH(2)) u_csi_port (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_clock_line_in(2'b00),
    .serial_clock_line_out(sck_o), .serial_clock_line_oe(), .serial_in_line(si),
    .serial_out_line(so), .slave_select_in_n(1'b1), .transfer_done_irq(irq));
  csi_peer u_peer0 (.sck(sck_o[0]), .so(so[0]), .clr(clr), .reply(reply[0]), .si(si[0]),
    .got(got[0]));
  csi_peer u_peer1 (.sck(sck_o[1]), .so(so[1]), .clr(clr), .reply(reply[1]), .si(si[1]),
    .got(got[1]));

  always #4 pclk = ~pclk;

  // Count done pulses per channel and cut a hang short.
  always @(posedge pclk) begin
    cycles++;
    for (int c = 0; c < 2; c++) irqs[c] += int'(irq[c] === 1'b1);
    if (cycles == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask

  // One APB transfer; the request is held until pready is seen at a rising edge.
  task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] wd,
                     output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {16'h0000, a};
    pwdata <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] x, input string what);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 8'h00, r, e);
    chk(r, {24'h00_0000, x}, what);
  endtask

  // One full frame; md selects direction and bit order, the bench predicts both bytes.
  task automatic frame(input int c, input logic [7:0] md);
    logic [31:0] r;
    logic        e;
    logic [7:0]  tx;
    int          n;
    int          base;
    tx = rnd[7:0];
    reply[c] = rnd[15:8];
    rnd = lfsr(rnd);
    clr <= 1'b1;
    wr(a_mode[c], md);
    clr <= 1'b0;
    base = irqs[c];
    chk(32'(sck_o[c]), 32'h0000_0000, "idle clock level");
    if (md[6]) wr(a_txb[c], tx);
    else apb(1'b0, a_shr[c], 8'h00, r, e);
    apb(1'b0, a_mode[c], 8'h00, r, e);
    chk(r, {24'h00_0000, md | 8'h01}, "busy during frame");
    n = 0;
    // Buffers and mode bits are left alone until busy has cleared.
    while (r[0] !== 1'b0 && n < 200) begin
      apb(1'b0, a_mode[c], 8'h00, r, e);
      n++;
    end
    chk(32'(irqs[c] - base), 32'h0000_0001, "done pulses");
    chk(32'(got[c]), 32'(md[6] ? (md[4] ? rev(tx) : tx) : 8'h00), "sent");
    rd_chk(a_shr[c], md[4] ? rev(reply[c]) : reply[c], "received");
    wr(a_mode[c], 8'h00);
    $display("test frame ch%0d mode %h done", c, md);
  endtask

  // Main sequence: reset state, both directions and bit orders on both channels, abort.
  initial begin
    logic [31:0] r;
    logic        e;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int c = 0; c < 2; c++) begin
      rd_chk(a_mode[c], 8'h00, "mode reset");
      rd_chk(a_txb[c], 8'h00, "txbuf reset");
      rd_chk(a_shr[c], 8'h00, "shift reset");
      wr(a_clk[c], 8'h02);
    end
    apb(1'b0, 16'hff70, 8'h00, r, e);
    chk(32'(e), 32'h0000_0001, "unmapped slave error");
    $display("test reset and map done");
    for (int c = 0; c < 2; c++)
      for (int m = 0; m < 4; m++) frame(c, 8'h80 | 8'(m[1] << 6) | 8'(m[0] << 4));
    wr(a_mode[1], 8'hc0);
    wr(a_txb[1], 8'ha5);
    wr(a_mode[1], 8'h00);
    rd_chk(a_mode[1], 8'h00, "abort clears busy");
    rd_chk(a_shr[1], 8'h00, "abort clears shift");
    wr(a_mode[0], 8'h01);
    rd_chk(a_mode[0], 8'h00, "busy not writable");
    wr(a_txb[0], 8'h3c);
    rd_chk(a_txb[0], 8'h3c, "txbuf readback");
    $display("test abort and access done");
    end_of_test();
  end

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
endmodule
